// ===== hw/crc_cfg.svh
// Purpose: constants for the codec path routing control block
// Assumes: 7-bit register addresses and 9-bit register words on the control port
// Notes: source codes are 2 bits; undefined codes route zero-valued samples
// Behaviour
// - Zero polarity bit inverts; all reset high
// - Polarity bits map DAC1L through DAC3R
// - Bit 4 bypasses ADC high-pass filter
// - ADC runs 128fs, 64fs for low master clocks
// - Bit 3 halves ADC oversampling rate
// - Bits 0 and 1 silence left, right ADC
// - Bit 2 silences both ADC channels
// - Any data input lane feeds any DAC
// - DAC1 lane also feeds optical, secondary transmitters
// - DAC1 source at bits 8:7, reset 11
// - DAC2/3 only primary data, may power down
// - Primary transmitter source bits 8:7, reset 01
// - Secondary transmitter source bits 8:7, reset 00
// - Optical transmitter source bits 1:0, reset 00
// - Bit 3 selects pass-through for optical pin
// - Rate mode bit 8 picks clock, power
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

`define CRC_ADDR_PRIMARY_C 7'h0c
`define CRC_ADDR_PRIMARY_D 7'h0d
`define CRC_ADDR_SECONDARY_B 7'h0e
`define CRC_ADDR_DAC_CTRL_A 7'h0f
`define CRC_ADDR_LANE_MAP 7'h1a
`define CRC_ADDR_POLARITY 7'h1b
`define CRC_ADDR_ADC_A 7'h1d
`define CRC_ADDR_OPTICAL_TX 7'h1e

`define CRC_RST_PRIMARY_C 9'h180
`define CRC_RST_PRIMARY_D 9'h080
`define CRC_RST_SECONDARY_B 9'h000
`define CRC_RST_DAC_CTRL_A 9'h000
`define CRC_RST_LANE_MAP 6'h24
`define CRC_RST_POLARITY 6'h3f
`define CRC_RST_ADC_A 9'h040
`define CRC_RST_OPTICAL_TX 9'h000

`define CRC_SRC_HI 8
`define CRC_SRC_LO 7
`define CRC_OTX_SRC_HI 1
`define CRC_OTX_SRC_LO 0
`define CRC_BIT_THROUGH 3
`define CRC_BIT_RATE_MODE 8
`define CRC_BIT_HPF_OFF 4
`define CRC_BIT_RATE_HALVE 3
`define CRC_BIT_BOTH_SIL 2
`define CRC_BIT_RIGHT_SIL 1
`define CRC_BIT_LEFT_SIL 0

`define CRC_CODE_SPDIF 2'h0
`define CRC_CODE_ADC 2'h1
`define CRC_CODE_SECONDARY 2'h2
`define CRC_CODE_PRIMARY 2'h3
`define CRC_LANE_RESERVED 2'h3
`define CRC_LANE_DIN1 2'h0
`define CRC_LANE_DIN2 2'h1
`define CRC_LANE_DIN3 2'h2

`define CRC_LANE1_HI 1
`define CRC_LANE1_LO 0
`define CRC_LANE2_HI 3
`define CRC_LANE2_LO 2
`define CRC_LANE3_HI 5
`define CRC_LANE3_LO 4

`define CRC_PHASE_DAC1_L 0
`define CRC_PHASE_DAC1_R 1
`define CRC_PHASE_DAC2_L 2
`define CRC_PHASE_DAC2_R 3
`define CRC_PHASE_DAC3_L 4
`define CRC_PHASE_DAC3_R 5

`endif

// ===== hw/crc_pkg.sv
// Purpose: shared types for the codec path routing control block
// Assumes: nothing beyond the constants header
// Notes: oversampling code is driven on the adc_osr port
package crc_pkg;
  typedef enum logic [1:0] {
    CRC_OSR_128,
    CRC_OSR_64,
    CRC_OSR_32
  } crc_osr_type;
endpackage

// ===== hw/crc_pair_buffer.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: source holds data while valid and not ready
// Notes: all outputs come from flip-flops; in_ready drops while the spare entry is full
`timescale 1ns/1ns
`default_nettype none
module crc_pair_buffer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic spare_valid_q;
  logic [WIDTH-1:0] spare_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_q;
  logic in_ready_q;
  logic take;

  assign take = in_valid && in_ready_q;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_q <= 1'b0;
      out_q <= '0;
      spare_valid_q <= 1'b0;
      spare_q <= '0;
      in_ready_q <= 1'b1;
    end else if (out_ready || !out_valid_q) begin
      if (spare_valid_q) begin
        out_q <= spare_q;
        out_valid_q <= 1'b1;
        spare_valid_q <= 1'b0;
        in_ready_q <= 1'b1;
      end else begin
        out_valid_q <= in_valid;
        if (in_valid) begin
          out_q <= in_data;
        end
      end
    end else if (take) begin
      // receiver stalled: park the word instead of dropping it
      spare_q <= in_data;
      spare_valid_q <= 1'b1;
      in_ready_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/crc_routing_top.sv
// Purpose: register bank and sample routing for the codec digital paths
// Assumes: sample sources and sinks run on core_clk; one stereo frame per transfer
// Notes: the optical input mux bit arrives from a pin and is synchronised
`timescale 1ns/1ns
`default_nettype none
`include "crc_cfg.svh"
module crc_routing_top #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic reg_wr_en,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  output logic [8:0] reg_rdata,
  // source frame
  input wire logic frame_valid,
  output logic frame_ready,
  input wire logic [W-1:0] spdif_rx_l,
  input wire logic [W-1:0] spdif_rx_r,
  input wire logic [W-1:0] adc_l,
  input wire logic [W-1:0] adc_r,
  input wire logic [W-1:0] secondary_rx_l,
  input wire logic [W-1:0] secondary_rx_r,
  input wire logic [W-1:0] din1_l,
  input wire logic [W-1:0] din1_r,
  input wire logic [W-1:0] din2_l,
  input wire logic [W-1:0] din2_r,
  input wire logic [W-1:0] din3_l,
  input wire logic [W-1:0] din3_r,
  // sink frame
  output logic sink_valid,
  input wire logic sink_ready,
  output logic [W-1:0] dac1_l,
  output logic [W-1:0] dac1_r,
  output logic [W-1:0] dac2_l,
  output logic [W-1:0] dac2_r,
  output logic [W-1:0] dac3_l,
  output logic [W-1:0] dac3_r,
  output logic [W-1:0] primary_tx_l,
  output logic [W-1:0] primary_tx_r,
  output logic [W-1:0] secondary_tx_l,
  output logic [W-1:0] secondary_tx_r,
  output logic [W-1:0] optical_tx_l,
  output logic [W-1:0] optical_tx_r,
  // adc and dac control
  input wire logic mclk_ratio_low,
  output logic adc_highpass_off,
  output logic [1:0] adc_osr,
  output logic dac23_powerdown,
  output logic dac_rate_from_subframe,
  // optical pin
  input wire logic optical_in_mux_bit,
  input wire logic optical_tx_bit,
  output logic optical_out_pin
);
  localparam int BW = 12 * W;

  logic [8:0] primary_c_q;
  logic [8:0] primary_d_q;
  logic [8:0] secondary_b_q;
  logic [8:0] dac_ctrl_a_q;
  logic [5:0] lane_map_q;
  logic [5:0] polarity_q;
  logic [8:0] adc_a_q;
  logic [8:0] optical_tx_q;
  logic [8:0] rdata_q;
  logic hpf_off_q;
  logic [1:0] osr_q;
  logic pd_q;
  logic subframe_q;
  logic pin_sync1_q;
  logic pin_sync2_q;
  logic opin_q;

  logic [1:0] dac1_src;
  logic [1:0] ptx_src;
  logic [1:0] stx_src;
  logic [1:0] otx_src;
  logic [1:0] lane1_sel;
  logic [1:0] lane2_sel;
  logic [1:0] lane3_sel;
  logic [W-1:0] adc_l_eff;
  logic [W-1:0] adc_r_eff;
  logic [W-1:0] lane1_l;
  logic [W-1:0] lane1_r;
  logic [W-1:0] lane2_l;
  logic [W-1:0] lane2_r;
  logic [W-1:0] lane3_l;
  logic [W-1:0] lane3_r;
  logic [W-1:0] d1_l;
  logic [W-1:0] d1_r;
  logic [W-1:0] pt_l;
  logic [W-1:0] pt_r;
  logic [W-1:0] st_l;
  logic [W-1:0] st_r;
  logic [W-1:0] ot_l;
  logic [W-1:0] ot_r;
  logic [BW-1:0] bundle_in;
  logic [BW-1:0] bundle_out;

  // negate with saturation at the most negative code
  // plain negation of the most negative code would give that code back
  function automatic logic [W-1:0] apply_phase(input logic [W-1:0] s, input logic keep);
    logic [W-1:0] most_neg;
    most_neg = {1'b1, {(W-1){1'b0}}};
    if (keep) begin
      return s;
    end
    if (s == most_neg) begin
      return ~most_neg;
    end
    return -s;
  endfunction

  // pick one of the three data input lanes; the spare code gives silence
  function automatic logic [W-1:0] pick_lane(input logic [1:0] code, input logic [W-1:0] a,
                                             input logic [W-1:0] b, input logic [W-1:0] c);
    unique case (code)
      `CRC_LANE_DIN1: return a;
      `CRC_LANE_DIN2: return b;
      `CRC_LANE_DIN3: return c;
      default: return '0;
    endcase
  endfunction

  // four-way source select; codes absent from ok are reserved and yield zero
  function automatic logic [W-1:0] pick_src(input logic [1:0] code, input logic [3:0] ok,
                                            input logic [W-1:0] spdif, input logic [W-1:0] adc,
                                            input logic [W-1:0] sec, input logic [W-1:0] pri);
    logic [W-1:0] v;
    v = '0;
    unique case (code)
      `CRC_CODE_SPDIF: v = spdif;
      `CRC_CODE_ADC: v = adc;
      `CRC_CODE_SECONDARY: v = sec;
      `CRC_CODE_PRIMARY: v = pri;
    endcase
    return ok[code] ? v : '0;
  endfunction

  // register writes
  // the six-bit registers keep only the low bits of the word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_c_q <= `CRC_RST_PRIMARY_C;
      primary_d_q <= `CRC_RST_PRIMARY_D;
      secondary_b_q <= `CRC_RST_SECONDARY_B;
      dac_ctrl_a_q <= `CRC_RST_DAC_CTRL_A;
      lane_map_q <= `CRC_RST_LANE_MAP;
      polarity_q <= `CRC_RST_POLARITY;
      adc_a_q <= `CRC_RST_ADC_A;
      optical_tx_q <= `CRC_RST_OPTICAL_TX;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `CRC_ADDR_PRIMARY_C: primary_c_q <= reg_wdata;
        `CRC_ADDR_PRIMARY_D: primary_d_q <= reg_wdata;
        `CRC_ADDR_SECONDARY_B: secondary_b_q <= reg_wdata;
        `CRC_ADDR_DAC_CTRL_A: dac_ctrl_a_q <= reg_wdata;
        `CRC_ADDR_LANE_MAP: lane_map_q <= reg_wdata[5:0];
        `CRC_ADDR_POLARITY: polarity_q <= reg_wdata[5:0];
        `CRC_ADDR_ADC_A: adc_a_q <= reg_wdata;
        `CRC_ADDR_OPTICAL_TX: optical_tx_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // readback, one cycle after the address; unmapped reads zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      unique case (reg_addr)
        `CRC_ADDR_PRIMARY_C: rdata_q <= primary_c_q;
        `CRC_ADDR_PRIMARY_D: rdata_q <= primary_d_q;
        `CRC_ADDR_SECONDARY_B: rdata_q <= secondary_b_q;
        `CRC_ADDR_DAC_CTRL_A: rdata_q <= dac_ctrl_a_q;
        `CRC_ADDR_LANE_MAP: rdata_q <= {3'h0, lane_map_q};
        `CRC_ADDR_POLARITY: rdata_q <= {3'h0, polarity_q};
        `CRC_ADDR_ADC_A: rdata_q <= adc_a_q;
        `CRC_ADDR_OPTICAL_TX: rdata_q <= optical_tx_q;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // source fields of the four routing registers
  assign dac1_src = primary_c_q[`CRC_SRC_HI:`CRC_SRC_LO];
  assign ptx_src = primary_d_q[`CRC_SRC_HI:`CRC_SRC_LO];
  assign stx_src = secondary_b_q[`CRC_SRC_HI:`CRC_SRC_LO];
  assign otx_src = optical_tx_q[`CRC_OTX_SRC_HI:`CRC_OTX_SRC_LO];

  // lane fields of the lane map, one per dac
  assign lane1_sel = lane_map_q[`CRC_LANE1_HI:`CRC_LANE1_LO];
  assign lane2_sel = lane_map_q[`CRC_LANE2_HI:`CRC_LANE2_LO];
  assign lane3_sel = lane_map_q[`CRC_LANE3_HI:`CRC_LANE3_LO];

  // adc input mutes; the both-channel bit overrides the individual ones
  assign adc_l_eff = (adc_a_q[`CRC_BIT_LEFT_SIL] || adc_a_q[`CRC_BIT_BOTH_SIL]) ? '0 : adc_l;
  assign adc_r_eff = (adc_a_q[`CRC_BIT_RIGHT_SIL] || adc_a_q[`CRC_BIT_BOTH_SIL]) ? '0 : adc_r;

  // primary receiver lane steering, two bits per dac
  assign lane1_l = pick_lane(lane1_sel, din1_l, din2_l, din3_l);
  assign lane1_r = pick_lane(lane1_sel, din1_r, din2_r, din3_r);
  assign lane2_l = pick_lane(lane2_sel, din1_l, din2_l, din3_l);
  assign lane2_r = pick_lane(lane2_sel, din1_r, din2_r, din3_r);
  assign lane3_l = pick_lane(lane3_sel, din1_l, din2_l, din3_l);
  assign lane3_r = pick_lane(lane3_sel, din1_r, din2_r, din3_r);

  // dac1: no adc source, code 01 reserved
  assign d1_l = pick_src(dac1_src, 4'b1101, spdif_rx_l, adc_l_eff, secondary_rx_l, lane1_l);
  assign d1_r = pick_src(dac1_src, 4'b1101, spdif_rx_r, adc_r_eff, secondary_rx_r, lane1_r);
  // primary transmitter: code 11 reserved
  assign pt_l = pick_src(ptx_src, 4'b0111, spdif_rx_l, adc_l_eff, secondary_rx_l, lane1_l);
  assign pt_r = pick_src(ptx_src, 4'b0111, spdif_rx_r, adc_r_eff, secondary_rx_r, lane1_r);
  // secondary transmitter: code 10 reserved; primary data is the dac1 lane
  assign st_l = pick_src(stx_src, 4'b1011, spdif_rx_l, adc_l_eff, secondary_rx_l, lane1_l);
  assign st_r = pick_src(stx_src, 4'b1011, spdif_rx_r, adc_r_eff, secondary_rx_r, lane1_r);
  // optical transmitter: all four codes defined
  assign ot_l = pick_src(otx_src, 4'b1111, spdif_rx_l, adc_l_eff, secondary_rx_l, lane1_l);
  assign ot_r = pick_src(otx_src, 4'b1111, spdif_rx_r, adc_r_eff, secondary_rx_r, lane1_r);

  // dac2/3 always take primary lanes; polarity applied at each dac
  assign bundle_in = {
    apply_phase(d1_l, polarity_q[`CRC_PHASE_DAC1_L]),
    apply_phase(d1_r, polarity_q[`CRC_PHASE_DAC1_R]),
    apply_phase(lane2_l, polarity_q[`CRC_PHASE_DAC2_L]),
    apply_phase(lane2_r, polarity_q[`CRC_PHASE_DAC2_R]),
    apply_phase(lane3_l, polarity_q[`CRC_PHASE_DAC3_L]),
    apply_phase(lane3_r, polarity_q[`CRC_PHASE_DAC3_R]),
    pt_l, pt_r, st_l, st_r, ot_l, ot_r
  };

  // a stalled sink parks one frame; frame_ready falls until it drains
  crc_pair_buffer #(
    .WIDTH(BW)
  ) u_buffer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(frame_valid),
    .in_data(bundle_in),
    .in_ready(frame_ready),
    .out_valid(sink_valid),
    .out_data(bundle_out),
    .out_ready(sink_ready)
  );

  // routed words leave straight from the buffer's output flops
  assign {dac1_l, dac1_r, dac2_l, dac2_r, dac3_l, dac3_r,
          primary_tx_l, primary_tx_r, secondary_tx_l, secondary_tx_r,
          optical_tx_l, optical_tx_r} = bundle_out;

  // adc filter and oversampling controls
  // mclk_ratio_low marks a 128fs or 192fs master clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hpf_off_q <= 1'b0;
      osr_q <= 2'h0;
    end else begin
      hpf_off_q <= adc_a_q[`CRC_BIT_HPF_OFF];
      if (mclk_ratio_low) begin
        osr_q <= adc_a_q[`CRC_BIT_RATE_HALVE] ? crc_pkg::CRC_OSR_32 : crc_pkg::CRC_OSR_64;
      end else begin
        osr_q <= adc_a_q[`CRC_BIT_RATE_HALVE] ? crc_pkg::CRC_OSR_64 : crc_pkg::CRC_OSR_128;
      end
    end
  end
  assign adc_highpass_off = hpf_off_q;
  assign adc_osr = osr_q;

  // dac rate source and dac2/3 power when dac1 plays received optical data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_q <= 1'b0;
      subframe_q <= 1'b0;
    end else begin
      pd_q <= (dac1_src == `CRC_CODE_SPDIF) && !dac_ctrl_a_q[`CRC_BIT_RATE_MODE];
      subframe_q <= (dac1_src == `CRC_CODE_SPDIF) && !dac_ctrl_a_q[`CRC_BIT_RATE_MODE];
    end
  end
  assign dac23_powerdown = pd_q;
  assign dac_rate_from_subframe = subframe_q;

  // optical output pin: transmitter or synchronised pass-through
  // the pass-through pin is asynchronous, so only the second flop feeds the mux
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync1_q <= 1'b0;
      pin_sync2_q <= 1'b0;
      opin_q <= 1'b0;
    end else begin
      pin_sync1_q <= optical_in_mux_bit;
      pin_sync2_q <= pin_sync1_q;
      opin_q <= optical_tx_q[`CRC_BIT_THROUGH] ? pin_sync2_q : optical_tx_bit;
    end
  end
  assign optical_out_pin = opin_q;
endmodule
`default_nettype wire

// ===== hw/crc_routing_top_end.sv
// Purpose: closes the design file list; holds no logic
// Assumes: read after the other design files
// Notes: only restores the default net type
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== tb/crc_routing_asserts.sv
// Purpose: port-level checks for crc_routing_top
// Assumes: shadows of the routing registers follow writes seen on the port
// Notes: bound to the top module below
`timescale 1ns/1ns
`default_nettype none
`include "crc_cfg.svh"
module crc_routing_asserts #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic reg_wr_en,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic [8:0] reg_rdata,
  // frames
  input wire logic frame_valid,
  input wire logic frame_ready,
  input wire logic sink_valid,
  input wire logic sink_ready,
  input wire logic [W-1:0] dac1_l,
  // status and pin
  input wire logic mclk_ratio_low,
  input wire logic adc_highpass_off,
  input wire logic [1:0] adc_osr,
  input wire logic dac23_powerdown,
  input wire logic dac_rate_from_subframe,
  input wire logic optical_tx_bit,
  input wire logic optical_out_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] src_q;
  logic mode_q;
  logic thru_q;
  logic pd;
  assign pd = src_q == 2'h0 && !mode_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_q <= 2'h3;
      mode_q <= 1'b0;
      thru_q <= 1'b0;
    end else if (reg_wr_en) begin
      if (reg_addr == `CRC_ADDR_PRIMARY_C) src_q <= reg_wdata[8:7];
      if (reg_addr == `CRC_ADDR_DAC_CTRL_A) mode_q <= reg_wdata[8];
      if (reg_addr == `CRC_ADDR_OPTICAL_TX) thru_q <= reg_wdata[3];
    end
  end
  sequence adc_wr_s;
    reg_wr_en && reg_addr == `CRC_ADDR_ADC_A ##1 !reg_wr_en;
  endsequence
  sequence take_s;
    frame_valid && frame_ready;
  endsequence
  hpf_follow_a: assert property (adc_wr_s |=> adc_highpass_off == $past(reg_wdata[4], 2))
    else $error("highpass bypass wrong");
  osr_rate_a: assert property (adc_wr_s |=> adc_osr == $past(reg_wdata[3], 2) + $past(mclk_ratio_low))
    else $error("adc oversampling code wrong");
  adc_readback_a: assert property (adc_wr_s ##0 reg_addr == `CRC_ADDR_ADC_A |=> reg_rdata == $past(reg_wdata, 2))
    else $error("adc register readback wrong");
  take_valid_a: assert property (take_s |=> sink_valid)
    else $error("taken frame not offered");
  sink_hold_a: assert property (sink_valid && !sink_ready |=> sink_valid && $stable(dac1_l))
    else $error("stalled frame changed");
  spare_full_a: assert property (take_s ##0 (sink_valid && !sink_ready) |=> !frame_ready)
    else $error("ready stayed high with spare full");
  pin_direct_a: assert property (!thru_q |=> optical_out_pin == $past(optical_tx_bit))
    else $error("optical pin not from transmitter");
  power_mode_a: assert property (1'b1 |=> dac23_powerdown == $past(pd) && dac_rate_from_subframe == $past(pd))
    else $error("dac power or rate mode wrong");
endmodule
bind crc_routing_top crc_routing_asserts #(.W(W)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_ready(frame_ready), .sink_valid(sink_valid),
  .sink_ready(sink_ready), .dac1_l(dac1_l), .mclk_ratio_low(mclk_ratio_low), .adc_highpass_off(adc_highpass_off),
  .adc_osr(adc_osr), .dac23_powerdown(dac23_powerdown), .dac_rate_from_subframe(dac_rate_from_subframe),
  .optical_tx_bit(optical_tx_bit), .optical_out_pin(optical_out_pin)
);
`default_nettype wire

// ===== tb/crc_sink_model.sv
// Purpose: far-side processor that accepts routed frames
// Assumes: frames are packed twelve words, first word highest
// Notes: in slow mode ready is offered one cycle in four
`timescale 1ns/1ns
`default_nettype none
module crc_sink_model #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pacing
  input wire logic slow,
  // frame
  input wire logic sink_valid,
  output logic sink_ready,
  input wire logic [12*W-1:0] frame
);
  logic [12*W-1:0] got[$];
  logic [1:0] cnt = 2'h0;
  initial sink_ready = 1'b0;
  always @(posedge core_clk) begin
    if (arst_n && sink_valid && sink_ready) got.push_back(frame);
    #1;
    cnt = cnt + 2'h1;
    sink_ready = !slow || cnt == 2'h3;
  end
endmodule
`default_nettype wire

// ===== tb/codec_path_routing_control_tb.sv
// Purpose: self-checking bench for crc_routing_top
// Assumes: inputs change 1 ns after the rising edge
// Notes: source words are base plus lane number so routes are recognisable
`timescale 1ns/1ns
`default_nettype none
`include "crc_cfg.svh"
module codec_path_routing_control_tb;
  localparam int W = 24;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [8:0] reg_wdata = 9'h000;
  logic [8:0] reg_rdata;
  logic frame_valid = 1'b0;
  logic mclk_ratio_low = 1'b0;
  logic optical_in_mux_bit = 1'b0;
  logic optical_tx_bit = 1'b0;
  logic slow = 1'b0;
  logic blocked = 1'b0;
  logic frame_ready, sink_valid, sink_ready, adc_highpass_off, dac23_powerdown, dac_rate, optical_out_pin;
  logic [1:0] adc_osr;
  logic [W-1:0] src [12];
  logic [W-1:0] out [12];
  logic [12*W-1:0] fr;
  int fail_count = 0;
  int n_compared = 0;
  logic [6:0] ra [8] = '{7'h0c, 7'h0d, 7'h0e, 7'h1b, 7'h1d, 7'h1e, 7'h1a, 7'h7f};
  logic [8:0] rv [8] = '{9'h180, 9'h080, 9'h000, 9'h03f, 9'h040, 9'h000, 9'h024, 9'h000};
  int dsel [4] = '{1, 0, 3, 4};
  int psel [4] = '{1, 2, 3, 0};
  int ssel [4] = '{1, 2, 0, 4};
  int ol [4] = '{0, 1, 1, 0};
  int ow [4] = '{64, 72, 80, 88};
  int oo [4] = '{0, 2, 1, 1};
  int oh [4] = '{0, 0, 1, 1};
  crc_routing_top #(.W(W)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_ready(frame_ready), .spdif_rx_l(src[0]),
    .spdif_rx_r(src[1]), .adc_l(src[2]), .adc_r(src[3]), .secondary_rx_l(src[4]), .secondary_rx_r(src[5]),
    .din1_l(src[6]), .din1_r(src[7]), .din2_l(src[8]), .din2_r(src[9]), .din3_l(src[10]), .din3_r(src[11]),
    .sink_valid(sink_valid), .sink_ready(sink_ready), .dac1_l(out[0]), .dac1_r(out[1]), .dac2_l(out[2]),
    .dac2_r(out[3]), .dac3_l(out[4]), .dac3_r(out[5]), .primary_tx_l(out[6]), .primary_tx_r(out[7]),
    .secondary_tx_l(out[8]), .secondary_tx_r(out[9]), .optical_tx_l(out[10]), .optical_tx_r(out[11]),
    .mclk_ratio_low(mclk_ratio_low), .adc_highpass_off(adc_highpass_off), .adc_osr(adc_osr),
    .dac23_powerdown(dac23_powerdown), .dac_rate_from_subframe(dac_rate), .optical_in_mux_bit(optical_in_mux_bit),
    .optical_tx_bit(optical_tx_bit), .optical_out_pin(optical_out_pin)
  );
  crc_sink_model #(.W(W)) sink (
    .core_clk(core_clk), .arst_n(arst_n), .slow(slow), .sink_valid(sink_valid), .sink_ready(sink_ready),
    .frame({out[0], out[1], out[2], out[3], out[4], out[5], out[6], out[7], out[8], out[9], out[10], out[11]})
  );
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (frame_valid && !frame_ready) blocked <= 1'b1;
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr_en = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    reg_addr = a;
    step(1);
    ck("reg_rdata", W'(e), W'(reg_rdata));
  endtask
  // leaves frame_valid high so calls may follow back to back
  task automatic send(input int b);
    int n;
    n = 0;
    for (int k = 0; k < 12; k++) src[k] = W'(b + k / 2 + 1 + (k % 2) * 256);
    frame_valid = 1'b1;
    while (frame_ready !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    ck("frame_ready", 1, W'(frame_ready));
    step(1);
  endtask
  task automatic pop();
    int n;
    n = 0;
    while (sink.got.size() == 0 && n < 50) begin
      step(1);
      n++;
    end
    ck("frame_count", 1, W'(sink.got.size() != 0));
    if (sink.got.size() != 0) fr = sink.got.pop_front();
  endtask
  function automatic logic [W-1:0] wd(input int k);
    return fr[(11 - k) * W +: W];
  endfunction
  function automatic logic [W-1:0] ev(input int b, input int s);
    return (s == 0) ? '0 : W'(b + s);
  endfunction
  initial begin
    for (int k = 0; k < 12; k++) src[k] = '0;
    step(16);
    arst_n = 1'b1;
    step(1);
    for (int k = 0; k < 8; k++) rd(ra[k], rv[k]);
    for (int k = 0; k < 4; k++) begin
      mclk_ratio_low = ol[k][0];
      wr(`CRC_ADDR_ADC_A, 9'(ow[k]));
      ck("adc_osr", W'(oo[k]), W'(adc_osr));
      ck("adc_highpass_off", W'(oh[k]), W'(adc_highpass_off));
    end
    rd(`CRC_ADDR_ADC_A, 9'h058);
    for (int i = 0; i < 4; i++) begin
      wr(`CRC_ADDR_PRIMARY_C, 9'(i << 7));
      wr(`CRC_ADDR_PRIMARY_D, 9'(i << 7));
      wr(`CRC_ADDR_SECONDARY_B, 9'(i << 7));
      wr(`CRC_ADDR_OPTICAL_TX, 9'(i));
      send(i * 16);
      frame_valid = 1'b0;
      pop();
      ck("dac1_l", ev(i * 16, dsel[i]), wd(0));
      ck("primary_tx_l", ev(i * 16, psel[i]), wd(6));
      ck("secondary_tx_l", ev(i * 16, ssel[i]), wd(8));
      ck("optical_tx_l", ev(i * 16, i + 1), wd(10));
      ck("secondary_tx_r", ev(i * 16 + 256, ssel[i]), wd(9));
      ck("optical_tx_r", ev(i * 16 + 256, i + 1), wd(11));
    end
    wr(`CRC_ADDR_PRIMARY_C, 9'h000);
    ck("dac23_powerdown", 1, W'(dac23_powerdown));
    ck("dac_rate_from_subframe", 1, W'(dac_rate));
    wr(`CRC_ADDR_DAC_CTRL_A, 9'h100);
    ck("dac23_powerdown", 0, W'(dac23_powerdown));
    ck("dac_rate_from_subframe", 0, W'(dac_rate));
    wr(`CRC_ADDR_PRIMARY_C, 9'h180);
    wr(`CRC_ADDR_POLARITY, 9'h02a);
    send(64);
    frame_valid = 1'b0;
    pop();
    for (int k = 0; k < 6; k++) ck("dac_out", (k % 2) ? W'(324 + k / 2) : W'(-(68 + k / 2)), wd(k));
    rd(`CRC_ADDR_POLARITY, 9'h02a);
    wr(`CRC_ADDR_POLARITY, 9'h03f);
    wr(`CRC_ADDR_LANE_MAP, 9'h012);
    send(80);
    frame_valid = 1'b0;
    pop();
    for (int k = 0; k < 3; k++) ck("dac_l", W'(84 + (k + 2) % 3), wd(2 * k));
    ck("secondary_tx_l", W'(86), wd(8));
    wr(`CRC_ADDR_PRIMARY_D, 9'h080);
    for (int k = 0; k < 3; k++) begin
      wr(`CRC_ADDR_ADC_A, 9'(1 << k));
      send(96);
      frame_valid = 1'b0;
      pop();
      ck("primary_tx_l", (k == 1) ? W'(98) : '0, wd(6));
      ck("primary_tx_r", (k == 0) ? W'(354) : '0, wd(7));
    end
    slow = 1'b1;
    for (int k = 0; k < 4; k++) send(112 + k * 16);
    frame_valid = 1'b0;
    for (int k = 0; k < 4; k++) begin
      pop();
      ck("dac1_l", W'(118 + k * 16), wd(0));
    end
    ck("frame_ready_dropped", 1, W'(blocked));
    slow = 1'b0;
    optical_tx_bit = 1'b1;
    step(1);
    ck("optical_out_pin", 1, W'(optical_out_pin));
    optical_tx_bit = 1'b0;
    step(1);
    ck("optical_out_pin", 0, W'(optical_out_pin));
    wr(`CRC_ADDR_OPTICAL_TX, 9'h00b);
    optical_in_mux_bit = 1'b1;
    step(3);
    ck("optical_out_pin", 1, W'(optical_out_pin));
    optical_in_mux_bit = 1'b0;
    optical_tx_bit = 1'b1;
    step(3);
    ck("optical_out_pin", 0, W'(optical_out_pin));
    summarize();
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
